/* logic/ric_conditioner.sv */
// Purpose: Digital control, pulse blanking, deglitch, threshold control and status of the conditioner.
// Assumes: Front-end levels arrive asynchronously and are synchronised here.
// Notes: Registers are reached over AXI4-Lite; ce low freezes every flip-flop.
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the register offsets.
`default_nettype none
// Functional notes
// - Blanking is code times period over 32
// - Misc bit 7 selects automatic threshold
// - Manual cranking uses fixed programmed threshold
// - Zero crossing jumps threshold to ceiling
// - Threshold decays at mantissa/exponent rate
// - Conditioner-off bit disables output path
// - Polarity bit picks high or low pulses
// - Optional deglitch of about one percent
// - Single-ended select drives front end
// - Swap bit inverts the comparator level only
// - Midref-off bit detaches internal reference
// - Peak code captured into status 7..4
// - Peak code clears only on reset/command
// - One sticky clamp flag per polarity
// - Zero cranking register selects running set
// - Threshold code from active bits 7..4
module ric_conditioner (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic ce,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire ric_pkg::ric_fe_in_t fe_in,
   output ric_pkg::ric_fe_ctrl_t fe_ctrl,
   output logic conditioned_output
);
   typedef struct packed {
      logic [7:0] run;
      logic [7:0] aut;
      logic [7:0] misc;
      logic [7:0] crank;
      logic [3:0] peak;
      logic pflag;
      logic nflag;
      logic [7:0] s1;
      logic [7:0] s2;
      logic zc_d;
      logic filt;
      logic [ric_pkg::PW-1:0] gl_cnt;
      logic [ric_pkg::PW-1:0] ref_cnt;
      logic [ric_pkg::PW-1:0] period;
      logic out;
      logic [ric_pkg::PW-1:0] blank_cnt;
      logic [3:0] thr;
      ric_pkg::ric_tmode_t tmode;
      logic [20:0] step_cnt;
      logic aw_got;
      logic [7:0] awaddr;
      logic w_got;
      logic [7:0] wdata;
      logic wstrb0;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ric_state_t;

   localparam ric_state_t RST_STATE = '{run: ric_pkg::RST_RUN, aut: ric_pkg::RST_AUTO, misc: ric_pkg::RST_MISC,
      crank: ric_pkg::RST_CRANK, tmode: ric_pkg::TM_HOLD, default: '0};

   ric_state_t r_r;
   ric_state_t r_nxt;
   logic zc_rise;
   logic cmp;
   logic lvl;
   logic [7:0] active;
   logic [3:0] chosen;
   logic [22:0] gl_prod;
   logic [ric_pkg::PW-1:0] glim;
   logic [23:0] bprod;
   logic [ric_pkg::PW-1:0] blen;
   logic [20:0] step_len;
   logic wr_do;
   logic [7:0] wa;
   logic [7:0] ra;
   logic [7:0] rd_byte;
   logic rd_ok;
   logic wr_ok;
   logic clr_p;
   logic clr_n;
   logic peak_clr;

   // Bus ready outputs are combinational; valid, data and answers come from flip-flops.
   assign s_axi_awready = !r_r.aw_got && !r_r.bvalid;
   assign s_axi_wready = !r_r.w_got && !r_r.bvalid;
   assign s_axi_bvalid = r_r.bvalid;
   assign s_axi_bresp = r_r.bresp;
   assign s_axi_arready = !r_r.rvalid;
   assign s_axi_rvalid = r_r.rvalid;
   assign s_axi_rdata = r_r.rdata;
   assign s_axi_rresp = r_r.rresp;
   assign conditioned_output = r_r.out;

   // Front-end controls mirror the configuration flip-flops.
   assign fe_ctrl.threshold_code = r_r.thr;
   assign fe_ctrl.conditioner_off = r_r.misc[ric_pkg::MISC_OFF];
   assign fe_ctrl.single_ended_sel = r_r.misc[ric_pkg::MISC_SE];
   assign fe_ctrl.internal_midref_off = r_r.misc[ric_pkg::MISC_MIDREF];

   // Next-state logic for the whole block.
   always_comb begin
      r_nxt = r_r;
      // Two-stage synchronisers; the first stage feeds only the second.
      r_nxt.s1 = fe_in;
      r_nxt.s2 = r_r.s1;
      r_nxt.zc_d = r_r.s2[1];
      zc_rise = r_r.s2[1] && !r_r.zc_d;
      cmp = r_r.s2[0] ^ r_r.misc[ric_pkg::MISC_SWAP];
      active = (r_r.crank != 8'h00) ? r_r.crank : r_r.run;
      chosen = active[7:4];
      gl_prod = {3'h0, r_r.period} * 23'h000005;
      glim = ric_pkg::PW'(gl_prod >> 9);
      bprod = {4'h0, r_r.period} * {20'h00000, active[3:0]};
      blen = ric_pkg::PW'(bprod >> 5);
      step_len = 21'({1'b1, r_r.aut[7:4]}) << r_r.aut[3:0];

      // Edge deglitch: a new level must persist for about one percent of the period.
      if (!r_r.misc[ric_pkg::MISC_GLITCH]) begin
         r_nxt.filt = cmp;
         r_nxt.gl_cnt = '0;
      end else if (cmp == r_r.filt) begin
         r_nxt.gl_cnt = '0;
      end else if (r_r.gl_cnt >= glim) begin
         r_nxt.filt = cmp;
         r_nxt.gl_cnt = '0;
      end else begin
         r_nxt.gl_cnt = r_r.gl_cnt + 20'h00001;
      end

      // Reference pulse width, high or low pulses depending on polarity.
      lvl = r_r.filt ^ r_r.misc[ric_pkg::MISC_POL];
      if (lvl) begin
         if (r_r.ref_cnt != 20'hfffff) begin
            r_nxt.ref_cnt = r_r.ref_cnt + 20'h00001;
         end
      end else if (r_r.ref_cnt != '0) begin
         r_nxt.period = r_r.ref_cnt;
         r_nxt.ref_cnt = '0;
      end

      // One-shot blanking: after an output edge, further transitions wait.
      if (r_r.misc[ric_pkg::MISC_OFF]) begin
         r_nxt.out = 1'b0;
         r_nxt.blank_cnt = '0;
      end else if (r_r.blank_cnt != '0) begin
         r_nxt.blank_cnt = r_r.blank_cnt - 20'h00001;
      end else if (r_r.filt != r_r.out) begin
         r_nxt.out = r_r.filt;
         r_nxt.blank_cnt = blen;
      end

      // Threshold selection, manual or automatic with decay.
      if (!r_r.misc[ric_pkg::MISC_AUTO]) begin
         r_nxt.thr = chosen;
         r_nxt.tmode = ric_pkg::TM_HOLD;
      end else if (zc_rise) begin
         r_nxt.thr = ric_pkg::THR_CEILING;
         r_nxt.tmode = ric_pkg::TM_DECAY;
         r_nxt.step_cnt = step_len;
      end else begin
         case (r_r.tmode)
            ric_pkg::TM_DECAY: begin
               if (r_r.thr <= chosen) begin
                  r_nxt.thr = chosen;
                  r_nxt.tmode = ric_pkg::TM_HOLD;
               end else if (r_r.step_cnt == '0) begin
                  r_nxt.thr = r_r.thr - 4'h1;
                  r_nxt.step_cnt = step_len;
               end else begin
                  r_nxt.step_cnt = r_r.step_cnt - 21'h000001;
               end
            end
            default: begin
               r_nxt.thr = chosen;
            end
         endcase
      end

      // Write channel capture; address and data may come in either order.
      if (s_axi_awvalid && s_axi_awready) begin
         r_nxt.aw_got = 1'b1;
         r_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         r_nxt.w_got = 1'b1;
         r_nxt.wdata = s_axi_wdata[7:0];
         r_nxt.wstrb0 = s_axi_wstrb[0];
      end
      wr_do = r_r.aw_got && r_r.w_got;
      wa = {r_r.awaddr[7:2], 2'h0};
      wr_ok = 1'b1;
      clr_p = 1'b0;
      clr_n = 1'b0;
      peak_clr = 1'b0;
      if (wr_do) begin
         r_nxt.aw_got = 1'b0;
         r_nxt.w_got = 1'b0;
         r_nxt.bvalid = 1'b1;
         case (wa)
            ric_pkg::OFS_RUN: if (r_r.wstrb0) r_nxt.run = r_r.wdata;
            ric_pkg::OFS_AUTO: if (r_r.wstrb0) r_nxt.aut = r_r.wdata;
            ric_pkg::OFS_MISC: if (r_r.wstrb0) r_nxt.misc = r_r.wdata;
            ric_pkg::OFS_CRANK: if (r_r.wstrb0) r_nxt.crank = r_r.wdata;
            ric_pkg::OFS_STAT: begin
               clr_p = r_r.wstrb0 && r_r.wdata[ric_pkg::STAT_PFLAG];
               clr_n = r_r.wstrb0 && r_r.wdata[ric_pkg::STAT_NFLAG];
            end
            ric_pkg::OFS_CMD: peak_clr = r_r.wstrb0 && r_r.wdata[ric_pkg::CMD_PEAK_CLR];
            default: wr_ok = 1'b0;
         endcase
         r_nxt.bresp = wr_ok ? ric_pkg::RESP_OKAY : ric_pkg::RESP_SLVERR;
      end else if (r_r.bvalid && s_axi_bready) begin
         r_nxt.bvalid = 1'b0;
      end

      // Peak capture at the zero crossing wins over the clear command.
      if (zc_rise && !r_r.misc[ric_pkg::MISC_OFF]) begin
         r_nxt.peak = r_r.s2[7:4];
      end else if (peak_clr) begin
         r_nxt.peak = 4'h0;
      end
      // Sticky clamp flags; a new clamp event wins over the clear.
      r_nxt.pflag = (r_r.pflag && !clr_p) || r_r.s2[2];
      r_nxt.nflag = (r_r.nflag && !clr_n) || r_r.s2[3];

      // Read channel.
      ra = {s_axi_araddr[7:2], 2'h0};
      rd_ok = 1'b1;
      case (ra)
         ric_pkg::OFS_RUN: rd_byte = r_r.run;
         ric_pkg::OFS_AUTO: rd_byte = r_r.aut;
         ric_pkg::OFS_MISC: rd_byte = r_r.misc;
         ric_pkg::OFS_CRANK: rd_byte = r_r.crank;
         ric_pkg::OFS_STAT: rd_byte = {r_r.peak, 1'b0, r_r.pflag, r_r.nflag, 1'b0};
         ric_pkg::OFS_CMD: rd_byte = 8'h00;
         default: begin
            rd_byte = 8'h00;
            rd_ok = 1'b0;
         end
      endcase
      if (s_axi_arvalid && s_axi_arready) begin
         r_nxt.rvalid = 1'b1;
         r_nxt.rdata = {24'h000000, rd_byte};
         r_nxt.rresp = rd_ok ? ric_pkg::RESP_OKAY : ric_pkg::RESP_SLVERR;
      end else if (r_r.rvalid && s_axi_rready) begin
         r_nxt.rvalid = 1'b0;
      end
   end

   // State register with synchronous reset and clock enable.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_r <= RST_STATE;
      end else if (ce) begin
         r_r <= r_nxt;
      end
   end

   sequence s_jump;
      ce && r_r.misc[ric_pkg::MISC_AUTO] && zc_rise;
   endsequence
   sequence s_at_ceiling;
      r_r.thr == ric_pkg::THR_CEILING && r_r.tmode == ric_pkg::TM_DECAY;
   endsequence

   chk_auto_jump: assert property (@(posedge aclk) disable iff (!aresetn) s_jump |=> s_at_ceiling)
      else $error("threshold did not jump to ceiling");
   chk_decay_step: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && r_r.misc[ric_pkg::MISC_AUTO] && !zc_rise && r_r.tmode == ric_pkg::TM_DECAY && r_r.thr > chosen
      && r_r.step_cnt == '0 |=> r_r.thr == $past(r_r.thr) - 4'h1)
      else $error("decay step wrong");
   chk_manual_thr: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !r_r.misc[ric_pkg::MISC_AUTO] |=> fe_ctrl.threshold_code == $past(chosen))
      else $error("manual threshold not taken");
   chk_crank_sel: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !r_r.misc[ric_pkg::MISC_AUTO] && r_r.crank == 8'h00 |=> r_r.thr == $past(r_r.run[7:4]))
      else $error("running set not used");
   chk_blank_load: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !r_r.misc[ric_pkg::MISC_OFF] && r_r.blank_cnt == '0 && r_r.filt != r_r.out
      |=> r_r.blank_cnt == ric_pkg::PW'(({4'h0, $past(r_r.period)} * {20'h00000, $past(active[3:0])}) >> 5))
      else $error("blanking length wrong");
   chk_blank_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !r_r.misc[ric_pkg::MISC_OFF] && r_r.blank_cnt != '0 |=> $stable(conditioned_output))
      else $error("output moved inside blanking");
   chk_off_out: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && r_r.misc[ric_pkg::MISC_OFF] |=> !conditioned_output)
      else $error("output active while off");
   chk_glitch_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && r_r.misc[ric_pkg::MISC_GLITCH] && r_r.gl_cnt < glim |=> $stable(r_r.filt))
      else $error("glitch passed filter");
   chk_peak_hold: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && !zc_rise && !peak_clr |=> $stable(r_r.peak))
      else $error("peak code changed without cause");
   chk_clamp_set: assert property (@(posedge aclk) disable iff (!aresetn)
      ce && r_r.s2[2] |=> r_r.pflag [*1] ##0 s_axi_rdata[31:8] == 24'h000000)
      else $error("positive clamp flag not set");
endmodule // ric_conditioner
`default_nettype wire

/* logic/ric_pkg.sv */
// Purpose: Shared constants and carrier types for the reluctance input conditioner.
// Assumes: 32-bit AXI4-Lite register bus, 8-bit wide registers in the low byte lane.
// Notes: Offsets are byte addresses; every register takes one aligned word.
`default_nettype none
package ric_pkg;
   localparam int ADDR_W = 8;
   // Register byte offsets.
   localparam logic [7:0] OFS_RUN = 8'h00;
   localparam logic [7:0] OFS_AUTO = 8'h04;
   localparam logic [7:0] OFS_MISC = 8'h08;
   localparam logic [7:0] OFS_CRANK = 8'h0c;
   localparam logic [7:0] OFS_STAT = 8'h10;
   localparam logic [7:0] OFS_CMD = 8'h14;
   // Values after reset.
   localparam logic [7:0] RST_RUN = 8'h53;
   localparam logic [7:0] RST_AUTO = 8'h21;
   localparam logic [7:0] RST_MISC = 8'h00;
   localparam logic [7:0] RST_CRANK = 8'h00;
   // Miscellaneous register bit positions.
   localparam int MISC_AUTO = 7;
   localparam int MISC_OFF = 6;
   localparam int MISC_POL = 4;
   localparam int MISC_GLITCH = 3;
   localparam int MISC_SE = 2;
   localparam int MISC_SWAP = 1;
   localparam int MISC_MIDREF = 0;
   // Status register bit positions and command bit.
   localparam int STAT_PFLAG = 2;
   localparam int STAT_NFLAG = 1;
   localparam int CMD_PEAK_CLR = 0;
   // Pulse timing counter width and derived constants.
   localparam int PW = 20;
   localparam logic [3:0] THR_CEILING = 4'hf;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Threshold control modes.
   typedef enum logic [0:0] {TM_HOLD, TM_DECAY} ric_tmode_t;
   // Levels arriving from the analog front end.
   typedef struct packed {
      logic [3:0] peak_code;
      logic neg_clamp;
      logic pos_clamp;
      logic zero_cross;
      logic comparator;
   } ric_fe_in_t;
   // Controls sent to the analog front end.
   typedef struct packed {
      logic [3:0] threshold_code;
      logic conditioner_off;
      logic single_ended_sel;
      logic internal_midref_off;
   } ric_fe_ctrl_t;
endpackage
`default_nettype wire

/* verif/ric_host_model.sv */
// Purpose: Host-side model that watches the conditioned pulse train.
// Assumes: One clock; the output is a registered level.
// Notes: Counts rising edges so the bench can check what reached the host.
`default_nettype none
module ric_host_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic conditioned_output,
   output int edges
);
   timeunit 1ns;
   timeprecision 1ns;
   logic prev_r;
   // Count every rise of the pulse train that the host would see as a tooth.
   always @(posedge aclk) begin
      if (!aresetn) begin
         prev_r <= 1'b0;
         edges <= 0;
      end else begin
         prev_r <= conditioned_output;
         if (conditioned_output && !prev_r) edges <= edges + 1;
      end
   end
endmodule // ric_host_model
`default_nettype wire

/* verif/ric_conditioner_bench.sv */
// Purpose: Self-checking bench for the conditioner registers, threshold, status and output path.
// Assumes: 25 MHz clock, synchronous active-low reset, clock enable held high.
// Notes: Front-end levels are driven here; the host model counts output pulses.
`default_nettype none
module ric_conditioner_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic aclk = 1'b0, aresetn = 1'b0, ce = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp, r;
   logic [31:0] d;
   logic [7:0] v;
   ric_pkg::ric_fe_in_t fe = '0;
   ric_pkg::ric_fe_ctrl_t fc;
   logic cout;
   int edges, e0, n_errors = 0, num_checks = 0, cycles = 0;
   always #20 aclk = ~aclk;
   ric_conditioner DUT (.aclk(aclk), .aresetn(aresetn), .ce(ce), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
      .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .fe_in(fe), .fe_ctrl(fc), .conditioned_output(cout));
   ric_host_model host (.aclk(aclk), .aresetn(aresetn), .conditioned_output(cout), .edges(edges));
   // Prints the verdict and ends the run.
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   // Cuts a hang short.
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         stop_test();
      end
   end
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   // Write cycle: address and data offered together, each released when taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] dv);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, dv};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   // Read cycle: address held until taken, data taken with rvalid.
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask
   // Drives a zero-crossing rise long enough to pass the input synchroniser.
   task automatic zc();
      fe.zero_cross <= 1'b1;
      cyc(6);
      fe.zero_cross <= 1'b0;
      cyc(4);
   endtask
   initial begin
      void'($urandom(32'h3be0560c));
      cyc(3);
      aresetn <= 1'b1;
      // Reset values, read-only default threshold and an unmapped place.
      rd(ric_pkg::OFS_RUN); chk("run", 32'h53, d);
      rd(ric_pkg::OFS_AUTO); chk("auto", 32'h21, d);
      rd(ric_pkg::OFS_MISC); chk("misc", 32'h0, d);
      rd(ric_pkg::OFS_CRANK); chk("crank", 32'h0, d);
      chk("thr_rst", 32'h5, fc.threshold_code);
      rd(8'h3c); chk("unmapped", ric_pkg::RESP_SLVERR, r);
      // Random miscellaneous settings reach the front-end controls.
      repeat (4) begin
         v = 8'($urandom) & 8'h47;
         if (v[2]) v[0] = 1'b1;
         wr(ric_pkg::OFS_MISC, v);
         chk("bresp", ric_pkg::RESP_OKAY, r);
         cyc(2);
         chk("off", v[6], fc.conditioner_off);
         chk("se", v[2], fc.single_ended_sel);
         chk("midref", v[0], fc.internal_midref_off);
      end
      // Manual mode: non-zero cranking set wins, zero falls back to running set.
      wr(ric_pkg::OFS_MISC, 8'h00);
      repeat (3) begin
         v = 8'($urandom) | 8'h01;
         wr(ric_pkg::OFS_CRANK, v);
         cyc(2);
         chk("thr_crank", v[7:4], fc.threshold_code);
         v = 8'($urandom);
         wr(ric_pkg::OFS_CRANK, 8'h00);
         wr(ric_pkg::OFS_RUN, v);
         cyc(2);
         chk("thr_run", v[7:4], fc.threshold_code);
      end
      // Peak capture at zero crossing, retention and clear command.
      repeat (3) begin
         v = 8'($urandom);
         fe.peak_code <= v[3:0];
         cyc(4);
         zc();
         fe.peak_code <= ~v[3:0];
         cyc(4);
         rd(ric_pkg::OFS_STAT);
         chk("peak", v[3:0], d[7:4]);
      end
      wr(ric_pkg::OFS_CMD, 8'h01);
      rd(ric_pkg::OFS_STAT); chk("peak_clr", 32'h0, d[7:4]);
      // Each clamp flag sets from its own input and clears by writing one.
      for (int i = 1; i <= 2; i++) begin
         fe[2 + i - 1] <= 1'b1;
         cyc(5);
         fe[2 + i - 1] <= 1'b0;
         cyc(4);
         rd(ric_pkg::OFS_STAT); chk("clamp", (i == 1) ? 32'h4 : 32'h2, {29'h0, d[2:1], 1'b0});
         wr(ric_pkg::OFS_STAT, (i == 1) ? 8'h04 : 8'h02);
         rd(ric_pkg::OFS_STAT); chk("clamp_clr", 32'h0, d[2:1]);
      end
      // Automatic mode: jump to the ceiling, then decay to the chosen level.
      wr(ric_pkg::OFS_RUN, 8'h30);
      wr(ric_pkg::OFS_AUTO, 8'h00);
      wr(ric_pkg::OFS_MISC, 8'h80);
      fe.zero_cross <= 1'b1;
      cyc(4);
      chk("thr_max", ric_pkg::THR_CEILING, fc.threshold_code);
      cyc(300);
      chk("thr_decay", 32'h3, fc.threshold_code);
      fe.zero_cross <= 1'b0;
      // Output path: follow, swap and off.
      wr(ric_pkg::OFS_MISC, 8'h00);
      wr(ric_pkg::OFS_RUN, 8'h50);
      fe.comparator <= 1'b1;
      cyc(6);
      chk("out", 32'h1, cout);
      wr(ric_pkg::OFS_MISC, 8'h02);
      cyc(6);
      chk("out_swap", 32'h0, cout);
      wr(ric_pkg::OFS_MISC, 8'h42);
      fe.comparator <= 1'b0;
      cyc(6);
      chk("out_off", 32'h0, cout);
      // Blanking: measure a 64-cycle pulse, then a short bounce is stretched to the blanking length.
      wr(ric_pkg::OFS_MISC, 8'h00);
      wr(ric_pkg::OFS_RUN, 8'h5f);
      e0 = edges;
      fe.comparator <= 1'b1;
      cyc(64);
      fe.comparator <= 1'b0;
      cyc(64);
      fe.comparator <= 1'b1;
      cyc(8);
      fe.comparator <= 1'b0;
      cyc(8);
      chk("blank_hold", 32'h1, cout);
      cyc(40);
      chk("blank_end", 32'h0, cout);
      chk("host_edges", e0 + 2, edges);
      stop_test();
   end
endmodule // ric_conditioner_bench
`default_nettype wire
